//--- ecdr_engine.v
// enclave control page creation and debug read engine
`timescale 1ns/1ns
`include "ecdr_consts.vh"

// Contract
// - page info address 32-byte aligned else gp
// - destination 4 KB aligned else gp
// - destination outside page cache gives pf
// - source 4 KB, security info 64-byte aligned
// - linear and control fields zero else gp
// - security info reserved zero, type control page
// - locked entry gp, valid entry pf
// - copy the whole 4 KB source page
// - feature mask low bits set, legal
// - misc select checked, lock released on gp
// - save frame pages times 4096 big enough
// - base canonical or upper bits clear
// - size below capability exponent power of two
// - size at least 8192, power of two
// - base aligned on size
// - attributes supported, reserved fields zero
// - uninitialized, fresh measurement, ids cleared
// - absorb tagged 512-bit block, count update
// - fetch-add identifier, set map entry valid
// - debug read eight or four bytes
// - debug read faults on listed conditions
// - debug read ignores map permissions
// - concurrent map modifier gives gp
module ecdr_engine #(
  parameter AW = 64,
  parameter WORDS = 512
) (
  input wire clk_sys, // core clock
  input wire rst, // async reset, high
  input wire start, // leaf request pulse
  input wire [7:0] func_code, // leaf function code
  input wire mode_wide, // processor in 64-bit mode
  input wire cpl_zero, // privilege level is zero
  input wire seg_ok, // segment checks passed
  input wire [AW-1:0] info_addr, // page info address
  input wire [AW-1:0] dest_addr, // destination or source address
  input wire dest_in_cache, // address inside page cache
  input wire [AW-1:0] info_src_page, // page info source page pointer
  input wire [AW-1:0] info_sec_ptr, // page info security info pointer
  input wire [AW-1:0] info_linear, // page info linear address field
  input wire [AW-1:0] info_ctl_page, // page info control page field
  input wire sec_rsvd_nz, // security info reserved nonzero
  input wire [2:0] sec_page_type, // security info page type
  input wire entry_locked, // map entry locked elsewhere
  input wire entry_valid, // map entry valid
  input wire [2:0] entry_type, // map entry page type
  input wire entry_debug, // owning enclave is debug
  input wire map_busy, // other map modifier running
  input wire [11:0] tcs_limit, // thread page limit
  input wire [63:0] src_rdata, // source page word read data
  input wire [63:0] extended_feature_mask, // extended feature mask
  input wire extended_feature_mask_legal, // feature mask legal
  input wire [31:0] misc_sel, // misc state select
  input wire [31:0] misc_supported, // capability misc bits
  input wire [31:0] save_frame_pages, // save frame page count
  input wire [63:0] xsave_size, // computed save size
  input wire [63:0] attributes, // enclave attributes
  input wire [63:0] supported_attr_mask, // supported attributes
  input wire ctl_rsvd_nz, // control page reserved nonzero
  input wire [63:0] enclave_base, // enclave base
  input wire [63:0] enclave_size, // enclave size
  input wire [15:0] size_exp, // capability size exponents
  input wire [63:0] dbg_rdata, // debug read data
  input wire meas_ready, // measurement unit ready
  output reg busy, // leaf in progress
  output reg done, // leaf done pulse
  output reg [1:0] fault, // fault kind at done
  output reg [AW-1:0] fault_addr, // page fault address
  output reg [9:0] copy_idx, // copy word index
  output reg copy_we, // destination word write
  output reg [63:0] copy_wdata, // destination word data
  output reg lock_take, // take entry lock pulse
  output reg lock_release, // release entry lock pulse
  output reg meas_init, // fresh measurement pulse
  output reg meas_update, // absorb block pulse
  output reg [511:0] meas_block, // measurement block
  output reg [31:0] update_count, // measurement update counter
  output reg [63:0] enclave_identifier, // stored identifier
  output reg [63:0] next_identifier_counter, // global counter
  output reg clear_ids, // vendor ids cleared pulse
  output reg map_write, // map entry write pulse
  output reg [2:0] map_type, // written map type
  output reg [63:0] dest_reg, // debug read result
  output reg dest_reg_we // destination register write
);
  localparam S_IDLE = 3'h0;
  localparam S_COPY = 3'h1;
  localparam S_CHK = 3'h2;
  localparam S_MEAS = 3'h3;
  localparam S_FIN = 3'h4;

  reg [2:0] st_q;
  reg [1:0] pre_f;
  reg [1:0] post_f;
  reg [1:0] dbg_f;
  reg [63:0] szm1;
  reg [7:0] exp_sel;
  reg [6:0] ones;
  reg [43:0] need_bytes;
  reg [63:0] dbg_align_m;
  wire wide_attr = attributes[`ECDR_ATTR_WIDE_BIT];

  // leaf decode, only acted on while idle
  wire create_req = start && func_code == `ECDR_FN_CREATE;
  wire dbg_req = start && func_code == `ECDR_FN_DBGRD;

  function nz;
    input [63:0] v;
    input [63:0] m;
    begin
      nz = |(v & m);
    end
  endfunction

  // size must be a power of two, so count its ones
  function [6:0] popcnt64;
    input [63:0] v;
    integer k;
    begin
      popcnt64 = 7'h0;
      for (k = 0; k < 64; k = k + 1) begin
        popcnt64 = popcnt64 + {6'h0, v[k]};
      end
    end
  endfunction

  // upper bits 63:47 must all match
  function canon;
    input [63:0] v;
    begin
      canon = (&v[63:47]) || (~|v[63:47]);
    end
  endfunction

  // an exponent of 64 or more puts no limit on size
  function size_over;
    input [63:0] s;
    input [7:0] e;
    begin
      size_over = (e < 8'h40) && (s >= (64'h1 << e[5:0]));
    end
  endfunction

  // checks before any state change, first failing one wins
  always @* begin
    pre_f = `ECDR_FLT_NONE;
    if (nz(info_addr, `ECDR_INFO_ALIGN_MASK)) begin
      pre_f = `ECDR_FLT_GP;
    end else if (nz(dest_addr, `ECDR_PAGE_ALIGN_MASK)) begin
      pre_f = `ECDR_FLT_GP;
    end else if (!dest_in_cache) begin
      pre_f = `ECDR_FLT_PF;
    end else if (nz(info_src_page, `ECDR_PAGE_ALIGN_MASK) ||
                 nz(info_sec_ptr, `ECDR_SECURITY_INFO_STRUCT_ALIGN_MASK)) begin
      pre_f = `ECDR_FLT_GP;
    end else if ((|info_linear) || (|info_ctl_page)) begin
      pre_f = `ECDR_FLT_GP;
    end else if (sec_rsvd_nz || sec_page_type != `ECDR_TYPE_CONTROL_PAGE) begin
      pre_f = `ECDR_FLT_GP;
    end else if (entry_locked) begin
      pre_f = `ECDR_FLT_GP;
    end else if (entry_valid) begin
      pre_f = `ECDR_FLT_PF;
    end
  end

  // checks on the copied page, in listed order
  always @* begin
    post_f = `ECDR_FLT_NONE;
    szm1 = enclave_size - 64'h1;
    exp_sel = wide_attr ? size_exp[15:8] : size_exp[7:0];
    ones = popcnt64(enclave_size);
    // saturate so a huge save size still faults instead of wrapping
    need_bytes = (|xsave_size[63:44]) ? 44'hfffffffffff : xsave_size[43:0];
    if ((extended_feature_mask & `ECDR_EXTENDED_FEATURE_MASK_LOW_BITS) != `ECDR_EXTENDED_FEATURE_MASK_LOW_BITS || !extended_feature_mask_legal) begin
      post_f = `ECDR_FLT_GP;
    end else if (|(misc_sel & ~misc_supported)) begin
      post_f = `ECDR_FLT_GP;
    end else if ({save_frame_pages, 12'h0} < need_bytes) begin
      post_f = `ECDR_FLT_GP;
    end else if (wide_attr && !canon(enclave_base)) begin
      post_f = `ECDR_FLT_GP;
    end else if (!wide_attr && nz(enclave_base, `ECDR_NARROW_BASE_MASK)) begin
      post_f = `ECDR_FLT_GP;
    end else if (size_over(enclave_size, exp_sel)) begin
      post_f = `ECDR_FLT_GP;
    end else if (enclave_size < `ECDR_MIN_SIZE || ones > 7'h1) begin
      post_f = `ECDR_FLT_GP;
    end else if (nz(enclave_base, szm1)) begin
      post_f = `ECDR_FLT_GP;
    end else if (nz(attributes, ~supported_attr_mask) || ctl_rsvd_nz) begin
      post_f = `ECDR_FLT_GP;
    end
  end

  // map permissions are never looked at here
  always @* begin
    dbg_f = `ECDR_FLT_NONE;
    dbg_align_m = mode_wide ? `ECDR_QWORD_ALIGN_MASK : `ECDR_DWORD_ALIGN_MASK;
    if (!cpl_zero || !seg_ok) begin
      dbg_f = `ECDR_FLT_GP;
    end else if (nz(dest_addr, dbg_align_m)) begin
      dbg_f = `ECDR_FLT_GP;
    end else if (!dest_in_cache) begin
      dbg_f = `ECDR_FLT_PF;
    end else if (map_busy) begin
      dbg_f = `ECDR_FLT_GP;
    end else if (!entry_valid) begin
      dbg_f = `ECDR_FLT_PF;
    end else if (entry_type == `ECDR_TYPE_CONTROL_PAGE) begin
      dbg_f = `ECDR_FLT_GP;
    end else if (entry_type != `ECDR_PT_REG && entry_type != `ECDR_PT_TCS &&
                 entry_type != `ECDR_PT_VA) begin
      dbg_f = `ECDR_FLT_PF;
    // offset within the page against the thread page limit
    end else if (entry_type == `ECDR_PT_TCS && dest_addr[11:0] >= tcs_limit) begin
      dbg_f = `ECDR_FLT_GP;
    end else if (entry_type != `ECDR_PT_VA && !entry_debug) begin
      dbg_f = `ECDR_FLT_GP;
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= S_IDLE;
      busy <= 1'b0;
      done <= 1'b0;
      fault <= 2'h0;
      fault_addr <= {AW{1'b0}};
      copy_idx <= 10'h0;
      copy_we <= 1'b0;
      copy_wdata <= 64'h0;
      lock_take <= 1'b0;
      lock_release <= 1'b0;
      meas_init <= 1'b0;
      meas_update <= 1'b0;
      meas_block <= 512'h0;
      update_count <= 32'h0;
      enclave_identifier <= 64'h0;
      // identifier counter restarts at zero on every reset
      next_identifier_counter <= 64'h0;
      clear_ids <= 1'b0;
      map_write <= 1'b0;
      map_type <= 3'h0;
      dest_reg <= 64'h0;
      dest_reg_we <= 1'b0;
    end else begin
      done <= 1'b0;
      copy_we <= 1'b0;
      lock_take <= 1'b0;
      lock_release <= 1'b0;
      meas_init <= 1'b0;
      meas_update <= 1'b0;
      clear_ids <= 1'b0;
      map_write <= 1'b0;
      dest_reg_we <= 1'b0;
      case (st_q)
        S_IDLE: begin
          // unknown leaf codes fall through and raise nothing
          if (create_req) begin
            fault <= pre_f;
            if (pre_f != `ECDR_FLT_NONE) begin
              done <= 1'b1;
              fault_addr <= (pre_f == `ECDR_FLT_PF) ? dest_addr : {AW{1'b0}};
            end else begin
              busy <= 1'b1;
              lock_take <= 1'b1;
              copy_idx <= 10'h0;
              st_q <= S_COPY;
            end
          end else if (dbg_req) begin
            done <= 1'b1;
            fault <= dbg_f;
            fault_addr <= (dbg_f == `ECDR_FLT_PF) ? dest_addr : {AW{1'b0}};
            if (dbg_f == `ECDR_FLT_NONE) begin
              dest_reg <= mode_wide ? dbg_rdata : {32'h0, dbg_rdata[31:0]};
              dest_reg_we <= 1'b1;
            end
          end
        end
        S_COPY: begin
          // one word per cycle; read data is for copy_idx
          // copy_idx stops on the last word so the read stays in range
          copy_we <= 1'b1;
          copy_wdata <= src_rdata;
          if (copy_idx == WORDS[9:0] - 10'h1) begin
            st_q <= S_CHK;
          end else begin
            copy_idx <= copy_idx + 10'h1;
          end
        end
        S_CHK: begin
          if (post_f != `ECDR_FLT_NONE) begin
            // lock always dropped so a retry can proceed
            lock_release <= 1'b1;
            fault <= post_f;
            fault_addr <= {AW{1'b0}};
            done <= 1'b1;
            busy <= 1'b0;
            st_q <= S_IDLE;
          end else begin
            meas_init <= 1'b1;
            clear_ids <= 1'b1;
            update_count <= 32'h0;
            meas_block <= {352'h0, enclave_size, save_frame_pages, `ECDR_MEAS_TAG};
            st_q <= S_MEAS;
          end
        end
        S_MEAS: begin
          // a stalled hash unit just holds the block
          if (meas_ready) begin
            meas_update <= 1'b1;
            update_count <= update_count + 32'h1;
            st_q <= S_FIN;
          end
        end
        S_FIN: begin
          enclave_identifier <= next_identifier_counter;
          next_identifier_counter <= next_identifier_counter + 64'h1;
          map_write <= 1'b1;
          map_type <= `ECDR_TYPE_CONTROL_PAGE;
          lock_release <= 1'b1;
          // counter wraps only after 2^64 creates
          fault <= `ECDR_FLT_NONE;
          fault_addr <= {AW{1'b0}};
          done <= 1'b1;
          busy <= 1'b0;
          st_q <= S_IDLE;
        end
        default: begin
          st_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule // ecdr_engine

//--- ecdr_consts.vh
// constants for the enclave create and debug read engine
`ifndef ECDR_CONSTS_VH
`define ECDR_CONSTS_VH
`define ECDR_FN_CREATE 8'h00
`define ECDR_FN_DBGRD 8'h04
`define ECDR_INFO_ALIGN_MASK 64'h000000000000001f
`define ECDR_PAGE_ALIGN_MASK 64'h0000000000000fff
`define ECDR_SECURITY_INFO_STRUCT_ALIGN_MASK 64'h000000000000003f
`define ECDR_QWORD_ALIGN_MASK 64'h0000000000000007
`define ECDR_DWORD_ALIGN_MASK 64'h0000000000000003
`define ECDR_ATTR_WIDE_BIT 2
`define ECDR_EXTENDED_FEATURE_MASK_LOW_BITS 64'h0000000000000003
`define ECDR_NARROW_BASE_MASK 64'hffffffff00000000
`define ECDR_MIN_SIZE 64'h0000000000002000
`define ECDR_PAGE_BYTES 44'h00000001000
`define ECDR_MEAS_TAG 64'h0045544145524345
`define ECDR_PT_REG 3'h0
`define ECDR_TYPE_CONTROL_PAGE 3'h1
`define ECDR_PT_TCS 3'h2
`define ECDR_PT_VA 3'h3
`define ECDR_PAGE_WORDS 10'h200
`define ECDR_FLT_NONE 2'h0
`define ECDR_FLT_GP 2'h1
`define ECDR_FLT_PF 2'h2
`endif

//--- ecdr_engine_asserts.sv
// property checker for the enclave create and debug read engine
`timescale 1ns/1ns
`include "ecdr_consts.vh"
module ecdr_asserts #(
  parameter WORDS = 512
) (
  input wire clk_sys, // clock
  input wire rst, // reset
  input wire start, // request
  input wire [7:0] func_code, // leaf code
  input wire busy, // busy
  input wire done, // done
  input wire [1:0] fault, // fault kind
  input wire copy_we, // word write
  input wire lock_take, // lock taken
  input wire lock_release, // lock freed
  input wire meas_init, // hash start
  input wire meas_update, // hash block
  input wire clear_ids, // ids cleared
  input wire [31:0] update_count, // hash count
  input wire map_write, // map write
  input wire [2:0] map_type, // map type
  input wire dest_reg_we, // reg write
  input wire [63:0] next_identifier_counter // id counter
);
  reg [9:0] words_q; // words copied since the lock was taken
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      words_q <= 10'h0;
    else if (lock_take)
      words_q <= 10'h0;
    else if (copy_we)
      words_q <= words_q + 10'h1;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_dbg_answer;
    start && !busy && func_code == `ECDR_FN_DBGRD |=> done && !busy;
  endproperty
  a_dbg_answer: assert property (p_dbg_answer) else $error("debug read late");
  property p_dbg_we;
    dest_reg_we |-> done && fault == `ECDR_FLT_NONE;
  endproperty
  a_dbg_we: assert property (p_dbg_we) else $error("register written on fault");
  property p_unknown;
    start && !busy && func_code != `ECDR_FN_CREATE && func_code != `ECDR_FN_DBGRD |=> !busy;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown leaf taken");
  property p_early_clean;
    done && fault != `ECDR_FLT_NONE |-> !map_write && !meas_init && !meas_update;
  endproperty
  a_early_clean: assert property (p_early_clean) else $error("state changed on fault");
  property p_copy_len;
    meas_init |-> words_q == WORDS;
  endproperty
  a_copy_len: assert property (p_copy_len) else $error("copy length wrong");
  property p_fresh;
    meas_init |-> clear_ids && update_count == 32'h0 ##[1:20] meas_update;
  endproperty
  a_fresh: assert property (p_fresh) else $error("fresh hash missing");
  property p_count;
    meas_update |-> update_count == 32'h1 ##1 map_write;
  endproperty
  a_count: assert property (p_count) else $error("update count wrong");
  property p_map;
    map_write |-> done && lock_release && map_type == `ECDR_TYPE_CONTROL_PAGE &&
      next_identifier_counter == $past(next_identifier_counter) + 64'h1;
  endproperty
  a_map: assert property (p_map) else $error("map entry write wrong");
endmodule // ecdr_asserts
bind ecdr_engine ecdr_asserts #(.WORDS(WORDS)) u_chk (.*);

//--- ecdr_engine_tb_top.sv
// self-checking bench for the enclave create and debug read engine
`timescale 1ns/1ns
`include "ecdr_consts.vh"
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module ecdr_engine_tb_top;
  localparam WORDS = 4; // short page keeps the run brief
  logic clk_sys, rst, start;
  logic [7:0] func_code;
  int sel, mismatches, checks_done, lt, cyc;
  logic [9:0] wc;
  wire busy, done, copy_we, lock_take, lock_release, meas_init, meas_update, clear_ids;
  wire map_write, dest_reg_we, meas_ready;
  wire [1:0] fault;
  wire [2:0] map_type;
  wire [9:0] copy_idx;
  wire [31:0] update_count;
  wire [63:0] fault_addr, copy_wdata, enclave_identifier, next_identifier_counter, dest_reg;
  wire [511:0] meas_block;
  // every input is good unless sel picks the one fault case
  wire dbg = func_code == `ECDR_FN_DBGRD;
  wire mode_wide = sel != 41;
  wire cpl_zero = sel != 50;
  wire seg_ok = sel != 51;
  wire [63:0] dest_addr = sel == 2 ? 64'h3800 : sel == 41 || sel == 52 ? 64'h3004 :
    sel == 42 ? 64'h30f8 : sel == 58 ? 64'h3100 : 64'h3000;
  wire dest_in_cache = sel != 3 && sel != 53;
  wire [63:0] info_addr = sel == 1 ? 64'h50 : 64'h40;
  wire [63:0] info_src_page = sel == 4 ? 64'h5008 : 64'h5000;
  wire [63:0] info_sec_ptr = sel == 5 ? 64'h6020 : 64'h6040;
  wire [63:0] info_linear = {63'h0, sel == 6};
  wire [63:0] info_ctl_page = sel == 7 ? 64'h1000 : 64'h0;
  wire sec_rsvd_nz = sel == 8;
  wire [2:0] sec_page_type = sel == 9 ? `ECDR_PT_REG : `ECDR_TYPE_CONTROL_PAGE;
  wire entry_locked = sel == 10;
  wire entry_valid = dbg ? sel != 55 : sel == 11;
  wire [63:0] extended_feature_mask = sel == 12 ? 64'h1 : 64'h3;
  wire extended_feature_mask_legal = sel != 13;
  wire [31:0] misc_sel = sel == 14 ? 32'h3 : 32'h1;
  wire [31:0] misc_supported = 32'h1;
  wire [31:0] save_frame_pages = sel == 15 ? 32'h0 : 32'h1;
  wire [63:0] xsave_size = 64'h1000; // equal to one page: boundary passes
  wire [63:0] enclave_base = sel == 16 ? 64'h800000000000 : sel == 17 ? 64'h100000000 :
    sel == 21 ? 64'h1000 : 64'h0;
  wire [63:0] attributes = sel == 17 ? 64'h0 : sel == 22 ? 64'h104 : 64'h4;
  wire [63:0] supported_attr_mask = 64'hff;
  wire [63:0] enclave_size = sel == 18 ? 64'h100000000 : sel == 19 ? 64'h1000 :
    sel == 20 ? 64'h6000 : 64'h2000;
  wire [15:0] size_exp = 16'h2020;
  wire ctl_rsvd_nz = sel == 23;
  wire map_busy = sel == 54;
  wire [2:0] entry_type = sel == 56 ? `ECDR_TYPE_CONTROL_PAGE : sel == 57 ? 3'h5 :
    sel == 42 || sel == 58 ? `ECDR_PT_TCS : sel == 43 ? `ECDR_PT_VA : `ECDR_PT_REG;
  wire entry_debug = sel != 59 && sel != 43;
  wire [11:0] tcs_limit = 12'h100;
  wire [63:0] dbg_rdata = {32'h11223344, 24'h0, sel[7:0]};
  wire [63:0] src_rdata = {48'hc0de00000000, 6'h0, copy_idx};
  assign meas_ready = cyc[1]; // hash unit stalls every other pair of cycles
  ecdr_engine #(.WORDS(WORDS)) dut (.*);
  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (lock_take) begin
      wc = 10'h0;
      lt++;
    end
    if (copy_we) begin
      `CHK("copy_wdata", {48'hc0de00000000, 6'h0, wc}, copy_wdata)
      wc++;
    end
    #1 cyc++;
    if (cyc == 5000) begin
      mismatches++;
      conclude;
    end
  end
  task conclude;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task run(input logic [7:0] f, input int s);
    begin
      sel = s;
      func_code = f;
      start = 1'h1;
      @(posedge clk_sys);
      #1 start = 1'h0;
      while (done !== 1'h1) begin
        @(posedge clk_sys);
        #1;
      end
    end
  endtask
  task t_create_ok;
    for (int i = 0; i < 2; i++) begin
      run(`ECDR_FN_CREATE, 0);
      `CHK("create_ok", `ECDR_FLT_NONE, fault)
      `CHK("words", WORDS, wc)
      `CHK("hash_block", {352'h0, 64'h2000, 32'h1, `ECDR_MEAS_TAG}, meas_block)
      `CHK("updates", 32'h1, update_count)
      `CHK("eid", 64'(i), enclave_identifier)
    end
  endtask
  task t_create_bad;
    int e;
    for (int i = 1; i < 24; i++) begin
      e = lt;
      run(`ECDR_FN_CREATE, i);
      `CHK("create_err", i == 3 || i == 11 ? `ECDR_FLT_PF : `ECDR_FLT_GP, fault)
      `CHK("pf_addr", i == 3 || i == 11 ? 64'h3000 : 64'h0, fault_addr)
      if (i < 12) `CHK("early_lock", e, lt)
    end
    `CHK("id_kept", 64'h2, next_identifier_counter)
  endtask
  task t_dbg_ok;
    for (int i = 40; i < 44; i++) begin
      run(`ECDR_FN_DBGRD, i);
      `CHK("dbg_ok", `ECDR_FLT_NONE, fault)
      `CHK("dbg_data", {i == 41 ? 32'h0 : 32'h11223344, 24'h0, i[7:0]}, dest_reg)
    end
  endtask
  task t_dbg_bad;
    for (int i = 50; i < 60; i++) begin
      run(`ECDR_FN_DBGRD, i);
      `CHK("dbg_err", i == 53 || i == 55 || i == 57 ? `ECDR_FLT_PF : `ECDR_FLT_GP, fault)
    end
  endtask
  task t_unknown;
    begin
      func_code = 8'h05;
      start = 1'h1;
      @(posedge clk_sys);
      #1 start = 1'h0;
      repeat (3) begin
        @(posedge clk_sys);
        #1 `CHK("ignored", 1'h0, done | busy)
      end
    end
  endtask
  initial begin
    rst = 1'h1;
    start = 1'h0;
    func_code = 8'h0;
    repeat (12) @(posedge clk_sys);
    #1 rst = 1'h0;
    t_create_ok;
    t_create_bad;
    t_dbg_ok;
    t_dbg_bad;
    t_unknown;
    conclude;
  end
endmodule // ecdr_engine_tb_top
